// ### bench/test_timer_pair.sv
// testbench: register-level tests of the timer pair
`timescale 1ns/10ps
module test_timer_pair;
   logic       clk_i;
   logic       sys_rst_i;
   logic [7:0] sfr_addr_i;
   logic       sfr_wr_i;
   logic [7:0] sfr_wdata_i;
   logic [7:0] sfr_rdata_o;
   logic       timer_a_count_pin_i;
   logic       timer_b_count_pin_i;
   logic       ext_irq_input_a_i;
   logic       ext_irq_input_b_i;
   logic       irq_input_a_polarity_i;
   logic       irq_input_b_polarity_i;
   logic       ext_prescale_clk_i;
   logic       timer_a_irq_enable_i;
   logic       timer_b_irq_enable_i;
   logic       timer_a_vector_ack_i;
   logic       timer_b_vector_ack_i;
   logic       timer_a_irq_o;
   logic       timer_b_irq_o;
   logic       timer_b_tick_o;
   int         fails;
   int         checks;
   int         cycles;
   int         ticks;
   int         tick_base;
   logic [7:0] d;
   int         divs [3] = '{12, 4, 48};

   timer_pair i_timer_pair
   (
      .clk_i                  (clk_i),
      .sys_rst_i              (sys_rst_i),
      .sfr_addr_i             (sfr_addr_i),
      .sfr_wr_i               (sfr_wr_i),
      .sfr_wdata_i            (sfr_wdata_i),
      .sfr_rdata_o            (sfr_rdata_o),
      .timer_a_count_pin_i    (timer_a_count_pin_i),
      .timer_b_count_pin_i    (timer_b_count_pin_i),
      .ext_irq_input_a_i      (ext_irq_input_a_i),
      .ext_irq_input_b_i      (ext_irq_input_b_i),
      .irq_input_a_polarity_i (irq_input_a_polarity_i),
      .irq_input_b_polarity_i (irq_input_b_polarity_i),
      .ext_prescale_clk_i     (ext_prescale_clk_i),
      .timer_a_irq_enable_i   (timer_a_irq_enable_i),
      .timer_b_irq_enable_i   (timer_b_irq_enable_i),
      .timer_a_vector_ack_i   (timer_a_vector_ack_i),
      .timer_b_vector_ack_i   (timer_b_vector_ack_i),
      .timer_a_irq_o          (timer_a_irq_o),
      .timer_b_irq_o          (timer_b_irq_o),
      .timer_b_tick_o         (timer_b_tick_o)
   );

   // ----------------------------------------------------------------
   // clock, watchdog and tick counting
   // ----------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // a hung wait must still reach the verdict, so cap the run;
   // the tick pulse is combinational, so it is sampled mid-cycle
   always @(negedge clk_i)
   begin
      cycles = cycles + 1;
      if (timer_b_tick_o === 1'b1)
         ticks = ticks + 1;
      if (cycles == 20000)
      begin
         fails = fails + 1;
         $display("Error at %0t: run did not finish in time", $time);
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // access tasks and comparisons
   // ----------------------------------------------------------------
   // one write pulse, then an idle edge so strobes never merge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_i);
      sfr_addr_i  = a;
      sfr_wdata_i = v;
      sfr_wr_i    = 1'b1;
      @(negedge clk_i);
      sfr_wr_i    = 1'b0;
   endtask

   // read data is registered, so wait two edges with the address held
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk_i);
      sfr_addr_i = a;
      repeat (2) @(negedge clk_i);
      v = sfr_rdata_o;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      checks = checks + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // free-running prescaler phase makes some counts land within a span
   task automatic check_range(input logic [7:0] got, input int lo,
                              input int hi);
      checks = checks + 1;
      if (((got >= lo) && (got <= hi)) !== 1'b1)
      begin
         fails = fails + 1;
         $display("Error at %0t: got %h outside %0d..%0d", $time, got, lo,
                  hi);
      end
   endtask

   task automatic close_out();
      $display("checks %0d fails %0d", checks, fails);
      if ((fails == 0) && (checks > 0))
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial
   begin
      fails = 0; checks = 0; cycles = 0; ticks = 0;
      sys_rst_i = 1'b1; sfr_addr_i = 8'h00; sfr_wr_i = 1'b0;
      sfr_wdata_i = 8'h00; timer_a_count_pin_i = 1'b1;
      timer_b_count_pin_i = 1'b1; ext_irq_input_a_i = 1'b0;
      ext_irq_input_b_i = 1'b0; irq_input_a_polarity_i = 1'b1;
      irq_input_b_polarity_i = 1'b1; ext_prescale_clk_i = 1'b1;
      timer_a_irq_enable_i = 1'b0; timer_b_irq_enable_i = 1'b0;
      timer_a_vector_ack_i = 1'b0; timer_b_vector_ack_i = 1'b0;
      idle(12);
      sys_rst_i = 1'b0;
      // reset values, and an unmapped place that ignores writes
      for (int i = 8'h88; i <= 8'h8e; i++)
      begin
         rd(8'(i), d);
         check_byte(d, 8'h00);
      end
      wr(8'h90, 8'hff);
      rd(8'h90, d);
      check_byte(d, 8'h00);
      $display("test reset done");
      // control bits read back; flag gates interrupt by enable only
      wr(8'h88, 8'h0f);
      rd(8'h88, d);
      check_byte(d, 8'h0f);
      wr(8'h88, 8'h20);
      check_byte({7'h00, timer_a_irq_o}, 8'h00);
      timer_a_irq_enable_i = 1'b1;
      idle(1);
      check_byte({7'h00, timer_a_irq_o}, 8'h01);
      timer_a_vector_ack_i = 1'b1;
      idle(1);
      timer_a_vector_ack_i = 1'b0;
      rd(8'h88, d);
      check_byte(d, 8'h00);
      $display("test control done");
      // 13-bit wrap from 1fff sets the flag, high byte rolls to 00
      wr(8'h8e, 8'h04);
      wr(8'h89, 8'h00);
      wr(8'h8c, 8'hff);
      wr(8'h8a, 8'h1e);
      wr(8'h88, 8'h10);
      idle(4);
      rd(8'h88, d);
      check_byte(d, 8'h30);
      check_byte({7'h00, timer_a_irq_o}, 8'h01);
      wr(8'h88, 8'h00);
      rd(8'h8c, d);
      check_byte(d, 8'h00);
      rd(8'h8a, d);
      check_range(d & 8'h1f, 1, 20);
      $display("test thirteen bit done");
      // gate closed holds the count; inverted polarity opens it
      wr(8'h89, 8'h09);
      wr(8'h8a, 8'h00);
      wr(8'h8c, 8'h00);
      wr(8'h88, 8'h10);
      idle(20);
      rd(8'h8a, d);
      check_byte(d, 8'h00);
      irq_input_a_polarity_i = 1'b0;
      idle(20);
      wr(8'h88, 8'h00);
      rd(8'h8a, d);
      check_range(d, 15, 40);
      $display("test gate done");
      // auto-reload: low byte restarts from the untouched high byte
      wr(8'h89, 8'h02);
      wr(8'h8c, 8'h80);
      wr(8'h8a, 8'hfc);
      wr(8'h88, 8'h10);
      idle(10);
      rd(8'h88, d);
      check_byte(d, 8'h30);
      wr(8'h88, 8'h00);
      rd(8'h8c, d);
      check_byte(d, 8'h80);
      rd(8'h8a, d);
      check_range(d, 8'h80, 8'ha0);
      $display("test reload done");
      // external pin: each falling edge counts exactly once
      wr(8'h89, 8'h05);
      wr(8'h8a, 8'h00);
      wr(8'h8c, 8'h00);
      wr(8'h88, 8'h10);
      repeat (5)
      begin
         timer_a_count_pin_i = 1'b0;
         idle(6);
         timer_a_count_pin_i = 1'b1;
         idle(6);
      end
      wr(8'h88, 8'h00);
      rd(8'h8a, d);
      check_byte(d, 8'h05);
      $display("test count pin done");
      // prescaler codes: divided system clock, then external clock / 8
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h8e, 8'(c));
         wr(8'h89, 8'h01);
         wr(8'h8a, 8'h00);
         wr(8'h88, 8'h10);
         if (c < 3)
            idle(240);
         else
            repeat (16)
            begin
               ext_prescale_clk_i = 1'b0;
               idle(4);
               ext_prescale_clk_i = 1'b1;
               idle(4);
            end
         wr(8'h88, 8'h00);
         rd(8'h8a, d);
         if (c < 3)
            check_range(d, 240 / divs[c] - 1, 240 / divs[c] + 1);
         else
            check_range(d, 1, 3);
      end
      $display("test prescaler done");
      // split: b runs without its run bit and raises no flag
      wr(8'h8e, 8'h0c);
      wr(8'h89, 8'h13);
      wr(8'h8d, 8'hff);
      wr(8'h8b, 8'hf0);
      wr(8'h8c, 8'hf0);
      tick_base = ticks;
      idle(40);
      rd(8'h88, d);
      check_byte(d, 8'h00);
      check_range(8'(ticks - tick_base), 1, 3);
      wr(8'h88, 8'h40);
      idle(30);
      rd(8'h88, d);
      check_byte(d, 8'hc0);
      timer_b_irq_enable_i = 1'b1;
      idle(1);
      check_byte({7'h00, timer_b_irq_o}, 8'h01);
      timer_b_vector_ack_i = 1'b1;
      idle(1);
      timer_b_vector_ack_i = 1'b0;
      rd(8'h88, d);
      check_byte(d, 8'h40);
      $display("test split done");
      // mode 3 on timer b holds its count even when run is set
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h30);
      wr(8'h8b, 8'h55);
      wr(8'h88, 8'h40);
      idle(20);
      rd(8'h8b, d);
      check_byte(d, 8'h55);
      $display("test halt done");
      // timer b counts its own pin, held off until its gate opens
      wr(8'h89, 8'hd0);
      wr(8'h8b, 8'h00);
      wr(8'h8d, 8'h00);
      wr(8'h88, 8'h40);
      for (int g = 0; g < 2; g++)
      begin
         ext_irq_input_b_i = g[0];
         repeat (3)
         begin
            timer_b_count_pin_i = 1'b0;
            idle(6);
            timer_b_count_pin_i = 1'b1;
            idle(6);
         end
         rd(8'h8b, d);
         check_byte(d, 8'(3 * g));
      end
      wr(8'h88, 8'h00);
      $display("test pin b done");
      close_out();
   end
endmodule

// ### verilog/timer_pair.sv
// two counter/timers with four modes, gating, prescaler and flags
`timescale 1ns/10ps
module timer_pair
(
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic [7:0] sfr_wdata_i,
   output logic      [7:0] sfr_rdata_o,
   input  wire logic       timer_a_count_pin_i,
   input  wire logic       timer_b_count_pin_i,
   input  wire logic       ext_irq_input_a_i,
   input  wire logic       ext_irq_input_b_i,
   input  wire logic       irq_input_a_polarity_i,
   input  wire logic       irq_input_b_polarity_i,
   input  wire logic       ext_prescale_clk_i,
   input  wire logic       timer_a_irq_enable_i,
   input  wire logic       timer_b_irq_enable_i,
   input  wire logic       timer_a_vector_ack_i,
   input  wire logic       timer_b_vector_ack_i,
   output logic            timer_a_irq_o,
   output logic            timer_b_irq_o,
   output logic            timer_b_tick_o
);
   // ----------------------------------------------------------------
   // step function shared by both timers in modes 0 to 2
   // ----------------------------------------------------------------
   function automatic timer_pair_pkg::step_s step
   (
      input timer_pair_pkg::tmode_e m,
      input logic [7:0]             hi,
      input logic [7:0]             lo
   );
      timer_pair_pkg::step_s r;
      r.hi  = hi;
      r.lo  = lo + 8'h01;
      r.ovf = 1'b0;
      case (m)
         timer_pair_pkg::MODE_13BIT:
         begin
            // upper three low bits stay untouched
            r.lo  = {lo[7:5], lo[4:0] + 5'h01};
            r.hi  = (lo[4:0] == 5'h1f) ? hi + 8'h01 : hi;
            r.ovf = (lo[4:0] == 5'h1f) && (hi == 8'hff);
         end
         timer_pair_pkg::MODE_16BIT:
         begin
            r.hi  = (lo == 8'hff) ? hi + 8'h01 : hi;
            r.ovf = (lo == 8'hff) && (hi == 8'hff);
         end
         timer_pair_pkg::MODE_RELOAD:
         begin
            r.ovf = (lo == 8'hff);
            if (lo == 8'hff)
            begin
               r.lo = hi;
            end
         end
         default:
         begin
            r.ovf = 1'b0;
         end
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] ctrl_reg,  ctrl_next;
   logic [7:0] mode_reg,  mode_next;
   logic [7:0] clksel_reg, clksel_next;
   logic [7:0] a_lo_reg,  a_lo_next;
   logic [7:0] a_hi_reg,  a_hi_next;
   logic [7:0] b_lo_reg,  b_lo_next;
   logic [7:0] b_hi_reg,  b_hi_next;
   logic [7:0] rdata_reg, rdata_next;
   logic [5:0] pre_cnt_reg, pre_cnt_next;
   logic [2:0] ext_cnt_reg, ext_cnt_next;
   logic       tick_reg,  tick_next;
   logic [4:0] sync1_reg, sync2_reg, sync3_reg;

   timer_pair_pkg::tmode_e a_mode, b_mode;
   timer_pair_pkg::step_s  a_st, b_st;
   logic a_gate_ok, b_gate_ok, a_en, b_en, split_a;
   logic a_int_tick, b_int_tick, a_tick, b_tick, pre_tick;
   logic a_pin_fall, b_pin_fall, ext_fall;
   logic a_inc, b_inc, a_hi_inc, a_ovf, b_ovf, b_ovf_raw;

   // ----------------------------------------------------------------
   // input synchroniser: pins a, b, gates a, b, external clock
   // ----------------------------------------------------------------
   // the third stage exists only so edges never look at stage one
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         sync1_reg <= 5'h00;
         sync2_reg <= 5'h00;
         sync3_reg <= 5'h00;
      end
      else
      begin
         sync1_reg <= {ext_prescale_clk_i, ext_irq_input_b_i,
                       ext_irq_input_a_i, timer_b_count_pin_i,
                       timer_a_count_pin_i};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign a_pin_fall = sync3_reg[0] & ~sync2_reg[0];
   assign b_pin_fall = sync3_reg[1] & ~sync2_reg[1];
   assign ext_fall   = sync3_reg[4] & ~sync2_reg[4];

   // ----------------------------------------------------------------
   // clock sources and enables
   // ----------------------------------------------------------------
   assign a_mode  = timer_pair_pkg::tmode_e'(mode_reg[1:0]);
   assign b_mode  = timer_pair_pkg::tmode_e'(mode_reg[5:4]);
   assign split_a = (a_mode == timer_pair_pkg::MODE_SPLIT);
   assign pre_tick = tick_reg;

   // gating input active when it equals its polarity bit
   assign a_gate_ok = ~mode_reg[timer_pair_pkg::MODE_A_LSB +
                                timer_pair_pkg::NIB_GATE] |
                      (sync2_reg[2] == irq_input_a_polarity_i);
   assign b_gate_ok = ~mode_reg[timer_pair_pkg::MODE_B_LSB +
                                timer_pair_pkg::NIB_GATE] |
                      (sync2_reg[3] == irq_input_b_polarity_i);

   assign a_en = ctrl_reg[timer_pair_pkg::CTRL_TR_A] & a_gate_ok;
   // split timer a takes timer b's run bit away from it
   assign b_en = (b_mode != timer_pair_pkg::MODE_SPLIT) &&
                 (split_a ||
                  (ctrl_reg[timer_pair_pkg::CTRL_TR_B] & b_gate_ok));

   assign a_int_tick = clksel_reg[timer_pair_pkg::CLK_A_SYS] | pre_tick;
   assign b_int_tick = clksel_reg[timer_pair_pkg::CLK_B_SYS] | pre_tick;
   assign a_tick = mode_reg[timer_pair_pkg::MODE_A_LSB +
                            timer_pair_pkg::NIB_CTSEL] ?
                   a_pin_fall : a_int_tick;
   assign b_tick = (mode_reg[timer_pair_pkg::MODE_B_LSB +
                             timer_pair_pkg::NIB_CTSEL] && !split_a) ?
                   b_pin_fall : b_int_tick;

   assign a_inc    = a_en & a_tick;
   assign b_inc    = b_en & b_tick;
   assign a_hi_inc = split_a & ctrl_reg[timer_pair_pkg::CTRL_TR_B] &
                     a_int_tick;

   assign a_st = step(a_mode, a_hi_reg, a_lo_reg);
   assign b_st = step(b_mode, b_hi_reg, b_lo_reg);

   assign a_ovf     = a_inc & (split_a ? (a_lo_reg == 8'hff) : a_st.ovf);
   assign b_ovf_raw = b_inc & b_st.ovf;
   // b flag source: split high byte, else b itself
   assign b_ovf     = split_a ? (a_hi_inc & (a_hi_reg == 8'hff))
                              : b_ovf_raw;

   // ----------------------------------------------------------------
   // next-state logic for prescaler, counts, registers, read data
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [5:0] term;
      logic       flag_a, flag_b;
      term   = timer_pair_pkg::DIV_12;
      flag_a = 1'b0;
      flag_b = 1'b0;
      case (clksel_reg[1:0])
         2'h1:    term = timer_pair_pkg::DIV_4;
         2'h2:    term = timer_pair_pkg::DIV_48;
         default: term = timer_pair_pkg::DIV_12;
      endcase
      // prescaler divides system clock or external edges
      pre_cnt_next = pre_cnt_reg;
      ext_cnt_next = ext_cnt_reg;
      tick_next    = 1'b0;
      if (clksel_reg[1:0] == 2'h3)
      begin
         if (ext_fall)
         begin
            ext_cnt_next = ext_cnt_reg + 3'h1;
            tick_next    = (ext_cnt_reg == timer_pair_pkg::DIV_EXT8);
         end
      end
      else if (pre_cnt_reg >= term)
      begin
         pre_cnt_next = 6'h00;
         tick_next    = 1'b1;
      end
      else
      begin
         pre_cnt_next = pre_cnt_reg + 6'h01;
      end

      // counts advance; run bit never clears them
      a_lo_next = a_lo_reg;
      a_hi_next = a_hi_reg;
      b_lo_next = b_lo_reg;
      b_hi_next = b_hi_reg;
      if (a_inc)
      begin
         a_lo_next = split_a ? a_lo_reg + 8'h01 : a_st.lo;
         a_hi_next = split_a ? a_hi_reg : a_st.hi;
      end
      if (a_hi_inc)
      begin
         a_hi_next = a_hi_reg + 8'h01;
      end
      if (b_inc)
      begin
         b_lo_next = b_st.lo;
         b_hi_next = b_st.hi;
      end

      // flags: hardware set wins over vector clear and writes
      flag_a = ctrl_reg[timer_pair_pkg::CTRL_TF_A] & ~timer_a_vector_ack_i;
      flag_b = ctrl_reg[timer_pair_pkg::CTRL_TF_B] & ~timer_b_vector_ack_i;
      ctrl_next   = ctrl_reg;
      mode_next   = mode_reg;
      clksel_next = clksel_reg;
      if (sfr_wr_i)
      begin
         case (sfr_addr_i)
            timer_pair_pkg::ADDR_CTRL:
            begin
               ctrl_next = sfr_wdata_i;
               flag_a = sfr_wdata_i[timer_pair_pkg::CTRL_TF_A];
               flag_b = sfr_wdata_i[timer_pair_pkg::CTRL_TF_B];
            end
            timer_pair_pkg::ADDR_MODE:   mode_next   = sfr_wdata_i;
            timer_pair_pkg::ADDR_CLKSEL: clksel_next = sfr_wdata_i;
            timer_pair_pkg::ADDR_A_LOW:  a_lo_next   = sfr_wdata_i;
            timer_pair_pkg::ADDR_A_HIGH: a_hi_next   = sfr_wdata_i;
            timer_pair_pkg::ADDR_B_LOW:  b_lo_next   = sfr_wdata_i;
            timer_pair_pkg::ADDR_B_HIGH: b_hi_next   = sfr_wdata_i;
            default:                     ctrl_next   = ctrl_reg;
         endcase
      end
      ctrl_next[timer_pair_pkg::CTRL_TF_A] = flag_a | a_ovf;
      ctrl_next[timer_pair_pkg::CTRL_TF_B] = flag_b | b_ovf;

      // register read data, one cycle after the address
      case (sfr_addr_i)
         timer_pair_pkg::ADDR_CTRL:   rdata_next = ctrl_reg;
         timer_pair_pkg::ADDR_MODE:   rdata_next = mode_reg;
         timer_pair_pkg::ADDR_CLKSEL: rdata_next = clksel_reg;
         timer_pair_pkg::ADDR_A_LOW:  rdata_next = a_lo_reg;
         timer_pair_pkg::ADDR_A_HIGH: rdata_next = a_hi_reg;
         timer_pair_pkg::ADDR_B_LOW:  rdata_next = b_lo_reg;
         timer_pair_pkg::ADDR_B_HIGH: rdata_next = b_hi_reg;
         default:                     rdata_next = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         ctrl_reg    <= timer_pair_pkg::RST_BYTE;
         mode_reg    <= timer_pair_pkg::RST_BYTE;
         clksel_reg  <= timer_pair_pkg::RST_BYTE;
         a_lo_reg    <= timer_pair_pkg::RST_BYTE;
         a_hi_reg    <= timer_pair_pkg::RST_BYTE;
         b_lo_reg    <= timer_pair_pkg::RST_BYTE;
         b_hi_reg    <= timer_pair_pkg::RST_BYTE;
         rdata_reg   <= timer_pair_pkg::RST_BYTE;
         pre_cnt_reg <= 6'h00;
         ext_cnt_reg <= 3'h0;
         tick_reg    <= 1'b0;
      end
      else
      begin
         ctrl_reg    <= ctrl_next;
         mode_reg    <= mode_next;
         clksel_reg  <= clksel_next;
         a_lo_reg    <= a_lo_next;
         a_hi_reg    <= a_hi_next;
         b_lo_reg    <= b_lo_next;
         b_hi_reg    <= b_hi_next;
         rdata_reg   <= rdata_next;
         pre_cnt_reg <= pre_cnt_next;
         ext_cnt_reg <= ext_cnt_next;
         tick_reg    <= tick_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign sfr_rdata_o   = rdata_reg;
   // enable gates only the request, never the flag
   assign timer_a_irq_o = ctrl_reg[timer_pair_pkg::CTRL_TF_A] &
                          timer_a_irq_enable_i;
   assign timer_b_irq_o = ctrl_reg[timer_pair_pkg::CTRL_TF_B] &
                          timer_b_irq_enable_i;
   // b tick stays live in split mode for baud and trigger use
   assign timer_b_tick_o = b_ovf_raw;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   chk_a_stop_hold: assert property (
      (!a_en && !split_a && !sfr_wr_i) |=> $stable({a_hi_reg, a_lo_reg}))
      else $error("timer a moved while disabled");
   chk_a13_wrap: assert property (
      (a_mode == timer_pair_pkg::MODE_13BIT && a_inc && !sfr_wr_i &&
       a_hi_reg == 8'hff && a_lo_reg[4:0] == 5'h1f)
      |=> ctrl_reg[timer_pair_pkg::CTRL_TF_A] && a_hi_reg == 8'h00 &&
          a_lo_reg[4:0] == 5'h00)
      else $error("13-bit wrap wrong");
   chk_a16_wrap: assert property (
      (a_mode == timer_pair_pkg::MODE_16BIT && a_inc && !sfr_wr_i &&
       {a_hi_reg, a_lo_reg} == 16'hffff)
      |=> ctrl_reg[timer_pair_pkg::CTRL_TF_A] &&
          {a_hi_reg, a_lo_reg} == 16'h0000)
      else $error("16-bit wrap wrong");
   chk_b_reload: assert property (
      (b_mode == timer_pair_pkg::MODE_RELOAD && b_inc && !split_a &&
       !sfr_wr_i && b_lo_reg == 8'hff)
      |=> b_lo_reg == $past(b_hi_reg) && $stable(b_hi_reg))
      else $error("reload wrong");
   chk_b_halt: assert property (
      (b_mode == timer_pair_pkg::MODE_SPLIT && !sfr_wr_i)
      |=> $stable({b_hi_reg, b_lo_reg}))
      else $error("timer b moved in mode 3");
   chk_split_noflag: assert property (
      (split_a && !a_hi_inc && !sfr_wr_i &&
       !ctrl_reg[timer_pair_pkg::CTRL_TF_B])
      |=> !ctrl_reg[timer_pair_pkg::CTRL_TF_B])
      else $error("timer b set its flag in split mode");
   chk_set_wins: assert property (
      (a_ovf && timer_a_vector_ack_i) |=> ctrl_reg[timer_pair_pkg::CTRL_TF_A])
      else $error("overflow lost against clear");
   chk_irq_gate: assert property (
      (!timer_b_irq_enable_i) |-> !timer_b_irq_o)
      else $error("request without enable");
   chk_pin_edge: assert property (
      a_pin_fall |-> $past(sync2_reg[0]) && !sync2_reg[0])
      else $error("edge not from synchronised pin");
endmodule

// ### verilog/timer_pair_pkg.sv
// package: register map, field positions and timing counts of the timer pair
package timer_pair_pkg;
   // ----------------------------------------------------------------
   // register addresses on the special-function register port
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h88;
   localparam logic [7:0] ADDR_MODE   = 8'h89;
   localparam logic [7:0] ADDR_A_LOW  = 8'h8a;
   localparam logic [7:0] ADDR_B_LOW  = 8'h8b;
   localparam logic [7:0] ADDR_A_HIGH = 8'h8c;
   localparam logic [7:0] ADDR_B_HIGH = 8'h8d;
   localparam logic [7:0] ADDR_CLKSEL = 8'h8e;

   // ----------------------------------------------------------------
   // control register bit positions
   // ----------------------------------------------------------------
   localparam int CTRL_TF_B = 7;
   localparam int CTRL_TR_B = 6;
   localparam int CTRL_TF_A = 5;
   localparam int CTRL_TR_A = 4;

   // ----------------------------------------------------------------
   // mode register fields: one nibble per timer, timer b on top
   // ----------------------------------------------------------------
   localparam int MODE_B_LSB = 4;
   localparam int MODE_A_LSB = 0;
   localparam int NIB_GATE   = 3;
   localparam int NIB_CTSEL  = 2;

   // clock-select register fields
   localparam int CLK_B_SYS  = 3;
   localparam int CLK_A_SYS  = 2;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;

   // ----------------------------------------------------------------
   // prescaler divides, counted in system clocks or external edges
   // ----------------------------------------------------------------
   localparam logic [5:0] DIV_12 = 6'h0b;   // terminal count for /12
   localparam logic [5:0] DIV_4  = 6'h03;   // terminal count for /4
   localparam logic [5:0] DIV_48 = 6'h2f;   // terminal count for /48
   localparam logic [2:0] DIV_EXT8 = 3'h7;  // terminal count for external /8

   typedef enum logic [1:0]
   {
      MODE_13BIT,
      MODE_16BIT,
      MODE_RELOAD,
      MODE_SPLIT
   } tmode_e;

   // one timer's count after a step, with its wrap indication
   typedef struct packed
   {
      logic       ovf;
      logic [7:0] hi;
      logic [7:0] lo;
   } step_s;
endpackage
